// ===== hw/scsev_pkg.sv
// Functional notes
// - selection-in-progress set on arbitration win, cleared at end
// - target wrap only if allowed, one to zero
// - initiator wrap from all ones to zero
// - done at zero unless wrap allowed
// - done set in initiator role only by force bit
// - pio ready on REQ/ACK, cleared by latch access
// - dma finished on terminal count, fifos empty outbound
// - flags readable always, interrupt on enabled set
// - clear bit drops interrupt except on live bits, which drop with status, zero does nothing
// - force bit sets done flag and interrupt
// - first register clears wrap, done status too
// - second register clears status too, bit four zero
// - bit six drops driven attention signal
// - selection timeout sticky while timer enabled
// - attention flag follows initiator ATN, target only
// - bus reset flag sticky until cleared
// - phase mismatch live, qualified by req detected
// - bus idle after eight free clock periods
// - parity error flagged only when checking enabled
// - phase change sticky in initiator role
// - req detected set on REQ edge as initiator, cleared by ACK
package scsev_pkg;
  // register indices and byte addresses
  localparam logic [11:0] SCSEV_IDX_A     = 12'h34B;
  localparam logic [11:0] SCSEV_IDX_B     = 12'h34C;
  localparam logic [11:0] SCSEV_ADDR_A    = 12'(SCSEV_IDX_A * 4);
  localparam logic [11:0] SCSEV_ADDR_B    = 12'(SCSEV_IDX_B * 4);
  // first group bit positions
  localparam int          SCSEV_A_TARGET  = 7;
  localparam int          SCSEV_A_FORCE   = 7;
  localparam int          SCSEV_A_SELPROG = 4;
  localparam int          SCSEV_A_WRAP    = 3;
  localparam int          SCSEV_A_DONE    = 2;
  localparam int          SCSEV_A_PIO     = 1;
  localparam int          SCSEV_A_DMA     = 0;
  // second group bit positions
  localparam int          SCSEV_B_SELTMO  = 7;
  localparam int          SCSEV_B_ATN     = 6;
  localparam int          SCSEV_B_RST     = 5;
  localparam int          SCSEV_B_PHMIS   = 4;
  localparam int          SCSEV_B_IDLE    = 3;
  localparam int          SCSEV_B_PAR     = 2;
  localparam int          SCSEV_B_PHCHG   = 1;
  localparam int          SCSEV_B_REQ     = 0;
  // irq-capable, clearable and live bits
  localparam logic [15:0] SCSEV_IRQ_MASK  = 16'hFF1F;
  localparam logic [15:0] SCSEV_CLR_MASK  = 16'hAF7F;
  localparam logic [15:0] SCSEV_LIVE_MASK = 16'h5000;
  localparam logic [7:0]  SCSEV_RST_VAL   = 8'h00;
  // transfer counter
  localparam int          SCSEV_CNT_W     = 24;
  typedef logic [SCSEV_CNT_W-1:0] scsev_cnt_t;
  localparam scsev_cnt_t  SCSEV_CNT_ZERO  = 24'h000000;
  localparam scsev_cnt_t  SCSEV_CNT_ONE   = 24'h000001;
  localparam scsev_cnt_t  SCSEV_CNT_ONES  = 24'hFFFFFF;
  // bus idle wait, in clocks
  localparam logic [3:0]  SCSEV_IDLE_T    = 4'h8;
  // bus watcher state
  typedef enum logic [1:0] {
    SCSEV_BUSY = 2'b01,
    SCSEV_FREE = 2'b10
  } scsev_bus_e;
endpackage

// ===== hw/scsev_evt_if.sv
`timescale 1ns/1ps
// event pulses from the bus watcher to the flag logic
interface scsev_evt_if;
  logic req_rise;  // REQ leading edge
  logic ack_rise;  // ACK leading edge
  logic idle_ev;   // bus just became idle
  logic wrap_ev;   // counter wrapped
  logic done_ev;   // counter reached zero, done
  modport src (output req_rise, ack_rise, idle_ev, wrap_ev, done_ev);
  modport dst (input  req_rise, ack_rise, idle_ev, wrap_ev, done_ev);
endinterface

// ===== hw/scsev_bus_watch.sv
`timescale 1ns/1ps
// watches bus lines and counter, emits one-cycle events
module scsev_bus_watch (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              req_in,
  input  wire logic              ack_in,
  input  wire logic              bsy_in,
  input  wire logic              sel_in,
  input  wire logic              target_role,
  input  wire logic              counter_wrap_allow,
  input  wire scsev_pkg::scsev_cnt_t xfer_count,
  scsev_evt_if.src               evt
);
  import scsev_pkg::*;

  logic       req_prev_reg;  // last REQ sample
  logic       ack_prev_reg;  // last ACK sample
  logic [3:0] idle_cnt_reg;  // free periods seen
  scsev_bus_e bus_reg;       // busy or free
  scsev_cnt_t cnt_prev_reg;  // last counter value

  // edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_prev_reg <= 1'b0;
      ack_prev_reg <= 1'b0;
      cnt_prev_reg <= SCSEV_CNT_ZERO;
    end else begin
      req_prev_reg <= req_in;
      ack_prev_reg <= ack_in;
      cnt_prev_reg <= xfer_count;
    end
  end

  // count periods with both BSY and SEL negated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_reg <= 4'h0;
      bus_reg      <= SCSEV_BUSY;
    end else if (bsy_in || sel_in) begin
      idle_cnt_reg <= 4'h0;
      bus_reg      <= SCSEV_BUSY;
    end else begin
      case (bus_reg)
        SCSEV_BUSY: begin
          idle_cnt_reg <= idle_cnt_reg + 4'h1;
          if (idle_cnt_reg == SCSEV_IDLE_T - 4'h1) begin
            bus_reg <= SCSEV_FREE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign evt.req_rise = req_in & ~req_prev_reg;
  assign evt.ack_rise = ack_in & ~ack_prev_reg;
  // pulse as the eighth free period ends
  assign evt.idle_ev  = !(bsy_in || sel_in) && (bus_reg == SCSEV_BUSY) &&
                        (idle_cnt_reg == SCSEV_IDLE_T - 4'h1);
  // wrap: target one to zero if allowed, initiator from all ones
  assign evt.wrap_ev  = (xfer_count == SCSEV_CNT_ZERO) &&
                        ((target_role && counter_wrap_allow &&
                          cnt_prev_reg == SCSEV_CNT_ONE) ||
                         (!target_role && cnt_prev_reg == SCSEV_CNT_ONES));
  // done: target role, no wrap allowed
  assign evt.done_ev  = target_role && !counter_wrap_allow &&
                        (xfer_count == SCSEV_CNT_ZERO) &&
                        (cnt_prev_reg != SCSEV_CNT_ZERO);
endmodule // scsev_bus_watch

// ===== hw/scsev_top.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
// scsi event status flags, pending interrupts and their clear registers
module scsev_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // role and selection sequencing
  input  wire logic        target_role,
  input  wire logic        sel_arb_won,
  input  wire logic        sel_seq_end,
  input  wire logic        sel_timeout,
  input  wire logic        selection_timer_enable,
  // transfer counter
  input  wire logic        counter_wrap_allow,
  input  wire scsev_pkg::scsev_cnt_t xfer_count,
  // dma path
  input  wire logic        dma_mode,
  input  wire logic        dma_outbound,
  input  wire logic        scsi_fifo_empty,
  input  wire logic        host_fifo_empty,
  input  wire logic        terminal_count,
  // scsi bus lines
  input  wire logic        req_in,
  input  wire logic        ack_in,
  input  wire logic        atn_in,
  input  wire logic        bsy_in,
  input  wire logic        sel_in,
  input  wire logic        bus_reset_in,
  input  wire logic [2:0]  bus_phase,
  input  wire logic [2:0]  expected_phase_register,
  // parity
  input  wire logic        info_inbound,
  input  wire logic        parity_bad,
  input  wire logic        parity_check_enable,
  // pio data latch
  input  wire logic        pio_outbound,
  input  wire logic        latch_write,
  input  wire logic        latch_read,
  // attention driven by this device
  input  wire logic        atn_raise,
  output logic             atn_out,
  // interrupt enables and request
  input  wire logic [7:0]  int_enable_a,
  input  wire logic [7:0]  int_enable_b,
  output logic             irq
);
  import scsev_pkg::*;

  scsev_evt_if evt ();                 // watcher events

  logic        sel_prog_reg;           // selection in progress
  logic        wrap_reg;               // counter wrapped
  logic        done_reg;               // transfer done
  logic        pio_reg;                // pio ready
  logic        dma_reg;                // dma finished
  logic        seltmo_reg;             // selection timeout
  logic        rst_seen_reg;           // bus reset seen
  logic        idle_reg;               // bus idle
  logic        parity_reg;             // parity error
  logic        phchg_reg;              // phase change
  logic        reqdet_reg;             // req detected
  logic        atn_out_reg;            // attention we drive
  logic        attention_seen_flag;    // live attention flag
  logic        phase_mismatch_flag;    // live mismatch flag
  logic [15:0] pend_reg;               // pending interrupts
  logic [15:0] stat_prev_reg;          // status last cycle
  logic [31:0] prdata_reg;             // read data
  logic [7:0]  stat_a;                 // first status group
  logic [7:0]  stat_b;                 // second status group
  logic [15:0] stat_all;               // both groups
  logic [15:0] en_all;                 // both enable groups
  logic [7:0]  clr_a;                  // write-one pulses, first
  logic [7:0]  clr_b;                  // write-one pulses, second
  logic [15:0] clr_all;                // interrupt clear pulses
  logic        hit_a;                  // address selects first
  logic        hit_b;                  // address selects second
  logic        wr_acc;                 // write in access phase
  logic        phase_differs;          // expected vs bus phase
  logic        parity_sample;          // parity sampling edge
  logic        dma_done_cond;          // dma completion condition

  // bus events come from the watcher
  scsev_bus_watch u_watch (
    .pclk               (pclk),
    .presetn            (presetn),
    .req_in             (req_in),
    .ack_in             (ack_in),
    .bsy_in             (bsy_in),
    .sel_in             (sel_in),
    .target_role        (target_role),
    .counter_wrap_allow (counter_wrap_allow),
    .xfer_count         (xfer_count),
    .evt                (evt)
  );

  // address decode
  always_comb begin
    hit_a = 1'b0;
    hit_b = 1'b0;
    if (paddr == SCSEV_ADDR_A) begin
      hit_a = 1'b1;
    end else if (paddr == SCSEV_ADDR_B) begin
      hit_b = 1'b1;
    end
  end

  // write-one clear pulses
  assign wr_acc = psel & penable & pwrite;
  assign clr_a  = (wr_acc && hit_a) ? pwdata[7:0] : 8'h00;
  assign clr_b  = (wr_acc && hit_b) ? pwdata[7:0] : 8'h00;

  // zero wait states, error when unmapped
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(hit_a | hit_b);
  assign prdata  = prdata_reg;

  // read data loaded at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_a) begin
        prdata_reg <= {24'h000000, stat_a};
      end else if (hit_b) begin
        prdata_reg <= {24'h000000, stat_b};
      end else begin
        prdata_reg <= 32'h00000000;
      end
    end
  end

  // selection in progress until sequence ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_prog_reg <= 1'b0;
    end else if (sel_arb_won) begin
      sel_prog_reg <= 1'b1;
    end else if (sel_seq_end) begin
      sel_prog_reg <= 1'b0;
    end
  end

  // counter wrap, cleared by write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_reg <= 1'b0;
    end else if (evt.wrap_ev) begin
      wrap_reg <= 1'b1;
    end else if (clr_a[SCSEV_A_WRAP]) begin
      wrap_reg <= 1'b0;
    end
  end

  // transfer done, also forced by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (evt.done_ev || clr_a[SCSEV_A_FORCE]) begin
      done_reg <= 1'b1;
    end else if (clr_a[SCSEV_A_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  // pio ready: REQ edge as initiator, ACK edge as target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pio_reg <= 1'b0;
    end else if (target_role ? evt.ack_rise : evt.req_rise) begin
      pio_reg <= 1'b1;
    end else if (pio_outbound ? latch_write : latch_read) begin
      pio_reg <= 1'b0;
    end
  end

  // outbound dma waits for empty fifos
  assign dma_done_cond = dma_mode && terminal_count &&
                         (!dma_outbound || (scsi_fifo_empty && host_fifo_empty));

  // dma flag is only meaningful in dma mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_reg <= 1'b0;
    end else if (dma_done_cond) begin
      dma_reg <= 1'b1;
    end else if (!dma_mode) begin
      dma_reg <= 1'b0;
    end
  end

  // selection timeout while the timer is enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seltmo_reg <= 1'b0;
    end else if (sel_timeout && selection_timer_enable) begin
      seltmo_reg <= 1'b1;
    end else if (clr_b[SCSEV_B_SELTMO]) begin
      seltmo_reg <= 1'b0;
    end
  end

  // bus reset seen, sticky
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_seen_reg <= 1'b0;
    end else if (bus_reset_in) begin
      rst_seen_reg <= 1'b1;
    end else if (clr_b[SCSEV_B_RST]) begin
      rst_seen_reg <= 1'b0;
    end
  end

  // bus idle, sticky until cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_reg <= 1'b0;
    end else if (evt.idle_ev) begin
      idle_reg <= 1'b1;
    end else if (clr_b[SCSEV_B_IDLE]) begin
      idle_reg <= 1'b0;
    end
  end

  // parity sampling edge by role
  assign parity_sample = info_inbound && (target_role ? evt.ack_rise : evt.req_rise);

  // parity error, zero while unchecked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_reg <= 1'b0;
    end else if (!parity_check_enable) begin
      parity_reg <= 1'b0;
    end else if (parity_sample && parity_bad) begin
      parity_reg <= 1'b1;
    end else if (clr_b[SCSEV_B_PAR]) begin
      parity_reg <= 1'b0;
    end
  end

  // phase change, initiator only
  assign phase_differs = (expected_phase_register != bus_phase);

  // sticky phase change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phchg_reg <= 1'b0;
    end else if (!target_role && phase_differs) begin
      phchg_reg <= 1'b1;
    end else if (clr_b[SCSEV_B_PHCHG]) begin
      phchg_reg <= 1'b0;
    end
  end

  // req detected, cleared by ACK or write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reqdet_reg <= 1'b0;
    end else if (!target_role && evt.req_rise) begin
      reqdet_reg <= 1'b1;
    end else if (ack_in || clr_b[SCSEV_B_REQ]) begin
      reqdet_reg <= 1'b0;
    end
  end

  // attention we drive, dropped by write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      atn_out_reg <= 1'b0;
    end else if (atn_raise) begin
      atn_out_reg <= 1'b1;
    end else if (clr_b[SCSEV_B_ATN]) begin
      atn_out_reg <= 1'b0;
    end
  end
  assign atn_out = atn_out_reg;

  // live flags follow their conditions
  assign attention_seen_flag = target_role & atn_in;
  assign phase_mismatch_flag = !target_role && reqdet_reg && phase_differs;

  // status groups as read by software
  always_comb begin
    stat_a                  = SCSEV_RST_VAL;
    stat_a[SCSEV_A_TARGET]  = target_role;
    stat_a[SCSEV_A_SELPROG] = sel_prog_reg;
    stat_a[SCSEV_A_WRAP]    = wrap_reg;
    stat_a[SCSEV_A_DONE]    = done_reg;
    stat_a[SCSEV_A_PIO]     = pio_reg;
    stat_a[SCSEV_A_DMA]     = dma_reg;
    stat_b                  = SCSEV_RST_VAL;
    stat_b[SCSEV_B_SELTMO]  = seltmo_reg;
    stat_b[SCSEV_B_ATN]     = attention_seen_flag;
    stat_b[SCSEV_B_RST]     = rst_seen_reg;
    stat_b[SCSEV_B_PHMIS]   = phase_mismatch_flag;
    stat_b[SCSEV_B_IDLE]    = idle_reg;
    stat_b[SCSEV_B_PAR]     = parity_reg;
    stat_b[SCSEV_B_PHCHG]   = phchg_reg;
    stat_b[SCSEV_B_REQ]     = reqdet_reg;
  end

  assign stat_all = {stat_b, stat_a};
  assign en_all   = {int_enable_b, int_enable_a};
  assign clr_all  = {clr_b, clr_a} & SCSEV_CLR_MASK;

  // status history for set detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_prev_reg <= 16'h0000;
    end else begin
      stat_prev_reg <= stat_all;
    end
  end

  // pending interrupt per flag; set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_pend
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend_reg[gi] <= 1'b0;
        end else if (stat_all[gi] && !stat_prev_reg[gi] &&
                     en_all[gi] && SCSEV_IRQ_MASK[gi]) begin
          pend_reg[gi] <= 1'b1;
        end else if (clr_all[gi] || (SCSEV_LIVE_MASK[gi] && !stat_all[gi])) begin
          pend_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // irq while any enabled interrupt pends
  assign irq = |(pend_reg & en_all);
endmodule // scsev_top

// ===== bench/scsev_checker.sv
`timescale 1ns/1ps
// watches the apb slave, atn_out and irq
module scsev_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        target_role,
  input wire logic        counter_wrap_allow,
  input wire logic [23:0] xfer_count,
  input wire logic        bus_reset_in,
  input wire logic        atn_raise,
  input wire logic        atn_out,
  input wire logic [7:0]  int_enable_a,
  input wire logic [7:0]  int_enable_b,
  input wire logic        irq
);
  import scsev_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write access phases
  wire wr_a     = psel && penable && pwrite && paddr == SCSEV_ADDR_A;
  wire wr_b     = psel && penable && pwrite && paddr == SCSEV_ADDR_B;
  // read setup cycle
  wire rd_setup = psel && !penable && !pwrite;
  wire unmapped = paddr != SCSEV_ADDR_A && paddr != SCSEV_ADDR_B;

  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_unmapped; psel && penable && unmapped |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  property p_rd_upper; rd_setup |=> prdata[31:8] == 24'h000000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
  property p_rsv_a; rd_setup && paddr == SCSEV_ADDR_A |=> prdata[6:5] == 2'h0; endproperty
  a_rsv_a: assert property (p_rsv_a) else $error("bits 6:5 set");
  property p_atn_up; atn_raise |=> atn_out; endproperty
  a_atn_up: assert property (p_atn_up) else $error("atn not up");
  property p_atn_drop; wr_b && pwdata[6] && !atn_raise |=> !atn_out; endproperty
  a_atn_drop: assert property (p_atn_drop) else $error("atn not down");
  property p_irq_off; int_enable_a == 8'h00 && int_enable_b == 8'h00 |-> !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq unmasked");
  property p_force; wr_a && pwdata[7] && int_enable_a[2] |-> ##[1:3] irq; endproperty
  a_force: assert property (p_force) else $error("no force irq");
  property p_wrap;
    target_role && counter_wrap_allow && int_enable_a[3] && xfer_count == SCSEV_CNT_ONE
    ##1 xfer_count == SCSEV_CNT_ZERO |-> ##[1:3] irq;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap irq");
  property p_rst; $rose(bus_reset_in) && int_enable_b[5] |-> ##[1:3] irq; endproperty
  a_rst: assert property (p_rst) else $error("no reset irq");
endmodule // scsev_checker

bind scsev_top scsev_checker scsev_checker_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .target_role, .counter_wrap_allow, .xfer_count, .bus_reset_in,
  .atn_raise, .atn_out, .int_enable_a, .int_enable_b, .irq
);

// ===== bench/scsev_bus_dev.sv
`timescale 1ns/1ps
// far-side bus devices driving the block's bus lines
module scsev_bus_dev (
  input  wire logic pclk,
  output logic       req_in,
  output logic       ack_in,
  output logic       atn_in,
  output logic       bsy_in,
  output logic       sel_in,
  output logic       bus_reset_in,
  output logic [2:0] bus_phase
);
  // lines rest deasserted, phase at zero
  initial begin
    {req_in, ack_in, atn_in, bsy_in, sel_in, bus_reset_in} = 6'h00;
    bus_phase = 3'h0;
  end
  // one-cycle pulses, mask is {REQ, ACK, bus reset}
  task automatic pulse(input logic [2:0] v);
    @(posedge pclk);
    {req_in, ack_in, bus_reset_in} <= v;
    @(posedge pclk);
    {req_in, ack_in, bus_reset_in} <= 3'h0;
  endtask
  // initiator attention level
  task automatic set_atn(input logic v);
    @(posedge pclk);
    atn_in <= v;
  endtask
  // short busy period, then release
  task automatic busy_free;
    @(posedge pclk);
    {bsy_in, sel_in} <= 2'h3;
    repeat (2) @(posedge pclk);
    {bsy_in, sel_in} <= 2'h0;
  endtask
endmodule // scsev_bus_dev

// ===== bench/testbench.sv
`timescale 1ns/1ps
// directed tests of flags, clears and irq
module testbench;
  import scsev_pkg::*;
  `define CHK(nm, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("[ERR] %s expected %h seen %h", nm, e, g); \
    end \
  end
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, atn_out, err;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, rd;
  logic        target_role, sel_arb_won, sel_seq_end, sel_timeout, selection_timer_enable;
  logic        counter_wrap_allow, dma_mode, dma_outbound, scsi_fifo_empty, host_fifo_empty;
  logic        terminal_count, info_inbound, parity_bad, parity_check_enable, pio_outbound;
  logic        latch_write, latch_read, atn_raise;
  logic        req_in, ack_in, atn_in, bsy_in, sel_in, bus_reset_in;
  logic [2:0]  bus_phase, expected_phase_register;
  logic [7:0]  int_enable_a, int_enable_b, m;
  scsev_cnt_t  xfer_count;
  int          n_errors, samples_checked;
  // per event: bit, in group b, status kept after clear
  int          ev_bit [10] = '{7, 5, 2, 1, 0, 4, 1, 0, 2, 3};
  logic [9:0]  ev_b        = 10'h01F;
  logic [9:0]  ev_keep     = 10'h0E0;

  scsev_top scsev_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .target_role, .sel_arb_won, .sel_seq_end, .sel_timeout,
    .selection_timer_enable, .counter_wrap_allow, .xfer_count, .dma_mode, .dma_outbound,
    .scsi_fifo_empty, .host_fifo_empty, .terminal_count, .req_in, .ack_in, .atn_in,
    .bsy_in, .sel_in, .bus_reset_in, .bus_phase, .expected_phase_register, .info_inbound,
    .parity_bad, .parity_check_enable, .pio_outbound, .latch_write, .latch_read,
    .atn_raise, .atn_out, .int_enable_a, .int_enable_b, .irq
  );
  scsev_bus_dev scsev_bus_dev_inst (
    .pclk, .req_in, .ack_in, .atn_in, .bsy_in, .sel_in, .bus_reset_in, .bus_phase
  );

  // 100 MHz clock
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  // apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, ad, 24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
    if (n >= 16) n_errors++;
  endtask

  // count one to zero, then settle
  task automatic cnt_step;
    @(posedge pclk);
    xfer_count <= SCSEV_CNT_ONE;
    @(posedge pclk);
    xfer_count <= SCSEV_CNT_ZERO;
    repeat (3) @(posedge pclk);
  endtask

  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // tests take under 2000 cycles
  initial begin
    #50us;
    n_errors++;
    summarize();
  end

  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata, target_role, sel_arb_won, sel_seq_end,
     sel_timeout, selection_timer_enable, counter_wrap_allow, xfer_count, dma_mode,
     dma_outbound, scsi_fifo_empty, host_fifo_empty, terminal_count, info_inbound,
     parity_bad, parity_check_enable, pio_outbound, latch_write, latch_read, atn_raise,
     expected_phase_register, int_enable_a, int_enable_b} = '0;
    n_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    // reset values, unmapped access
    apb(1'h0, SCSEV_ADDR_A, 8'h00);
    `CHK("status_a reset", 32'h00000000, rd)
    apb(1'h0, SCSEV_ADDR_B, 8'h00);
    `CHK("status_b reset", 32'h00000000, rd & 32'hFFFFFFF7)
    apb(1'h0, 12'h000, 8'h00);
    `CHK("unmapped error", 1'h1, err)
    `CHK("unmapped data", 32'h00000000, rd)
    $display("test reset done");
    // per event: set, irq, clear, irq gone
    for (int k = 0; k < 10; k++) begin
      a = ev_b[k] ? SCSEV_ADDR_B : SCSEV_ADDR_A;
      m = 8'h01 << ev_bit[k];
      int_enable_a <= ev_b[k] ? 8'h00 : m;
      int_enable_b <= ev_b[k] ? m : 8'h00;
      case (k)
        0: begin
          selection_timer_enable <= 1'h1;
          sel_timeout <= 1'h1;
          @(posedge pclk);
          sel_timeout <= 1'h0;
        end
        1: scsev_bus_dev_inst.pulse(3'h1);
        2: begin
          {parity_check_enable, info_inbound, parity_bad} <= 3'h7;
          scsev_bus_dev_inst.pulse(3'h4);
        end
        3: expected_phase_register <= 3'h2;
        4: begin
          scsev_bus_dev_inst.pulse(3'h2);
          scsev_bus_dev_inst.pulse(3'h4);
        end
        5: begin
          sel_arb_won <= 1'h1;
          @(posedge pclk);
          sel_arb_won <= 1'h0;
        end
        6: begin
          latch_read <= 1'h1;
          @(posedge pclk);
          latch_read <= 1'h0;
          scsev_bus_dev_inst.pulse(3'h4);
        end
        7: begin
          {dma_mode, dma_outbound, host_fifo_empty, terminal_count} <= 4'hF;
          repeat (3) @(posedge pclk);
          apb(1'h0, SCSEV_ADDR_A, 8'h00);
          `CHK("dma with fifo busy", 8'h00, rd[7:0] & m)
          scsi_fifo_empty <= 1'h1;
        end
        8: apb(1'h1, SCSEV_ADDR_A, 8'h80);
        default: begin
          xfer_count <= SCSEV_CNT_ONES;
          @(posedge pclk);
          xfer_count <= SCSEV_CNT_ZERO;
        end
      endcase
      repeat (3) @(posedge pclk);
      `CHK("irq on event", 1'h1, irq)
      apb(1'h0, a, 8'h00);
      `CHK("flag set", m, rd[7:0] & m)
      expected_phase_register <= 3'h0;
      parity_bad <= 1'h0;
      // phase and parity sources quiet before the flag is cleared
      apb(1'h1, a, m);
      repeat (2) @(posedge pclk);
      `CHK("irq after clear", 1'h0, irq)
      apb(1'h0, a, 8'h00);
      `CHK("flag after clear", ev_keep[k] ? m : 8'h00, rd[7:0] & m)
    end
    `CHK("done in initiator", 1'h0, rd[2])
    $display("test events done");
    // target wrap if allowed, else done
    dma_mode <= 1'h0;
    {target_role, counter_wrap_allow} <= 2'h3;
    {int_enable_a, int_enable_b} <= 16'h0800;
    cnt_step();
    apb(1'h0, SCSEV_ADDR_A, 8'h00);
    `CHK("target wrap", 8'h98, rd[7:0] & 8'h9C)
    {counter_wrap_allow, sel_seq_end} <= 2'h1;
    cnt_step();
    sel_seq_end <= 1'h0;
    apb(1'h1, SCSEV_ADDR_A, 8'h00);
    apb(1'h0, SCSEV_ADDR_A, 8'h00);
    `CHK("target done", 8'h8C, rd[7:0] & 8'h9C)
    $display("test counter done");
    // attention in and out
    scsev_bus_dev_inst.set_atn(1'h1);
    repeat (2) @(posedge pclk);
    apb(1'h0, SCSEV_ADDR_B, 8'h00);
    `CHK("attention on", 8'h40, rd[7:0] & 8'h40)
    scsev_bus_dev_inst.set_atn(1'h0);
    repeat (2) @(posedge pclk);
    apb(1'h0, SCSEV_ADDR_B, 8'h00);
    `CHK("attention off", 8'h00, rd[7:0] & 8'h40)
    atn_raise <= 1'h1;
    @(posedge pclk);
    atn_raise <= 1'h0;
    @(posedge pclk);
    `CHK("atn driven", 1'h1, atn_out)
    apb(1'h1, SCSEV_ADDR_B, 8'h50);
    @(posedge pclk);
    `CHK("atn dropped", 1'h0, atn_out)
    $display("test attention done");
    // idle after eight free periods
    apb(1'h1, SCSEV_ADDR_B, 8'h08);
    scsev_bus_dev_inst.busy_free();
    apb(1'h0, SCSEV_ADDR_B, 8'h00);
    `CHK("idle too early", 8'h00, rd[7:0] & 8'h08)
    repeat (6) @(posedge pclk);
    apb(1'h0, SCSEV_ADDR_B, 8'h00);
    `CHK("idle after eight", 8'h08, rd[7:0] & 8'h08)
    $display("test idle done");
    summarize();
  end
endmodule // testbench
